// File: hdl/dsq_pkg.sv
// Package for the debug state sequencer status block.
// Assumes an 8-bit register port with a 9-bit byte address.
package dsq_pkg;

  // Register offsets
  localparam logic [8:0] OFF_CTRL   = 9'h100;
  localparam logic [8:0] OFF_SCR1   = 9'h107;
  localparam logic [8:0] OFF_SCR2   = 9'h108;
  localparam logic [8:0] OFF_SCR3   = 9'h109;
  localparam logic [8:0] OFF_EFR    = 9'h10A;
  localparam logic [8:0] OFF_STATUS = 9'h10B;

  // Control register fields
  localparam int unsigned ARM_BIT   = 7;
  localparam int unsigned FORCE_BIT = 6;
  localparam int unsigned EXTERNAL_EVENT_ENABLE_LSB  = 0;
  localparam logic [1:0]  EXTERNAL_EVENT_ENABLE_EXT  = 2'h2;

  // Next-state code fields in every state control register
  localparam int unsigned C0_LSB = 0;
  localparam int unsigned C1_LSB = 2;
  localparam int unsigned C3_LSB = 6;

  // Event flag positions
  localparam int unsigned FLAG_FORCE = 6;
  localparam int unsigned FLAG_EXT   = 4;

  // Next-state codes
  localparam logic [1:0] CODE_NONE  = 2'h0;
  localparam logic [1:0] CODE_A     = 2'h1;
  localparam logic [1:0] CODE_B     = 2'h2;
  localparam logic [1:0] CODE_FINAL = 2'h3;

  // State status field encodings
  localparam logic [2:0] SSF_IDLE  = 3'h0;
  localparam logic [2:0] SSF_S1    = 3'h1;
  localparam logic [2:0] SSF_S2    = 3'h2;
  localparam logic [2:0] SSF_S3    = 3'h3;
  localparam logic [2:0] SSF_FINAL = 3'h4;

  // Reset values
  localparam logic [7:0] RST_SCR  = 8'h00;
  localparam logic [7:0] RST_EFR  = 8'h00;
  localparam logic [1:0] RST_EXTERNAL_EVENT_ENABLE = 2'h0;

  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_S1    = 5'b00010,
    ST_S2    = 5'b00100,
    ST_S3    = 5'b01000,
    ST_FINAL = 5'b10000
  } dsq_state_t;

endpackage

// File: hdl/dsq_top.sv
// Debug state sequencer: next-state selection, event flags, state status.
// Assumes match inputs come from comparators on clk_sys, already gated by
// their enables; the external event arrives from a pin.
//
// Notes on behaviour
// - Second state: 00 none,01 first,10 third,11 final
// - Third state: 00 none,01 first,10 second,11 final
// - Highest matching channel's code wins
// - Codes at bits 1-0, 3-2, 7-6 per state
// - External event replaces channel 3 when enable=10
// - State control registers writable only while disarmed
// - Flag and status registers ignore writes
// - Flags set on events only while armed
// - Force flag set when armed or arming
// - Flags cleared only by arming
// - Flags record independently of each other
// - Force bit 6, external bit 4, matches 3-0
// - Status follows every sequencer transition except software disarm
// - Software disarm keeps last status value
// - Internal session end returns idle, status 000
// - Arming enters first state, status 001
// - Status codes 000,001,010,011,100; rest reserved
// - Arm clears itself on return to idle
// - Force request goes final, reads zero
//
// The address-and-strobe port was chosen for this implementation.
module dsq_top (
  // Clock and reset
  input  wire logic       clk_sys,
  input  wire logic       rst_n,
  // Register port
  input  wire logic [8:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Event sources
  input  wire logic [3:0] match_in,
  input  wire logic       ext_event_in,
  // Status
  output logic            armed,
  output logic      [2:0] state_code
);

  typedef struct packed {
    logic                arm;
    logic [1:0]          external_event_enable;
    logic [7:0]          scr1;
    logic [7:0]          scr2;
    logic [7:0]          scr3;
    logic [7:0]          efr;
    logic [2:0]          state_status_field;
    dsq_pkg::dsq_state_t st;
    logic                ext_s1;
    logic                ext_s2;
    logic                ext_q;
    logic [7:0]          rdata;
  } dsq_regs_t;

  dsq_regs_t q;
  dsq_regs_t d;

  logic       ext_ev;
  logic       ch3_ev;
  logic       wr_ctrl;
  logic       arming;
  logic       force_req;
  logic [7:0] cur_scr;
  logic [1:0] code;
  logic       any_ev;

  // Code to state mapping; the meaning of 01/10 depends on the current state
  function automatic dsq_pkg::dsq_state_t pick_state(input dsq_pkg::dsq_state_t cur,
                                                     input logic [1:0]          c);
    dsq_pkg::dsq_state_t nxt;
    nxt = cur;
    unique case (c)
      dsq_pkg::CODE_NONE:  nxt = cur;
      dsq_pkg::CODE_A:     nxt = (cur == dsq_pkg::ST_S1) ? dsq_pkg::ST_S2
                                                         : dsq_pkg::ST_S1;
      dsq_pkg::CODE_B:     nxt = (cur == dsq_pkg::ST_S3) ? dsq_pkg::ST_S2
                                                         : dsq_pkg::ST_S3;
      dsq_pkg::CODE_FINAL: nxt = dsq_pkg::ST_FINAL;
    endcase
    return nxt;
  endfunction

  // Status encoding of each state
  function automatic logic [2:0] ssf_of(input dsq_pkg::dsq_state_t s);
    logic [2:0] v;
    v = dsq_pkg::SSF_IDLE;
    unique case (s)
      dsq_pkg::ST_IDLE:  v = dsq_pkg::SSF_IDLE;
      dsq_pkg::ST_S1:    v = dsq_pkg::SSF_S1;
      dsq_pkg::ST_S2:    v = dsq_pkg::SSF_S2;
      dsq_pkg::ST_S3:    v = dsq_pkg::SSF_S3;
      dsq_pkg::ST_FINAL: v = dsq_pkg::SSF_FINAL;
      default:           v = dsq_pkg::SSF_IDLE;
    endcase
    return v;
  endfunction

  // Event decode; the pin event is edge-detected after two sync flops
  always_comb begin
    ext_ev    = q.ext_s2 & ~q.ext_q;
    ch3_ev    = (q.external_event_enable == dsq_pkg::EXTERNAL_EVENT_ENABLE_EXT) ? ext_ev : match_in[3];
    wr_ctrl   = reg_wr && (reg_addr == dsq_pkg::OFF_CTRL);
    arming    = wr_ctrl && reg_wdata[dsq_pkg::ARM_BIT] && !q.arm;
    force_req = wr_ctrl && reg_wdata[dsq_pkg::FORCE_BIT]
                && (q.arm || reg_wdata[dsq_pkg::ARM_BIT]);
    unique case (q.st)
      dsq_pkg::ST_S1: cur_scr = q.scr1;
      dsq_pkg::ST_S2: cur_scr = q.scr2;
      dsq_pkg::ST_S3: cur_scr = q.scr3;
      default:        cur_scr = 8'h00;
    endcase
    // Highest channel takes precedence even if its code is 00
    any_ev = 1'b1;
    if (ch3_ev) begin
      code = cur_scr[dsq_pkg::C3_LSB +: 2];
    end else if (match_in[1]) begin
      code = cur_scr[dsq_pkg::C1_LSB +: 2];
    end else if (match_in[0]) begin
      code = cur_scr[dsq_pkg::C0_LSB +: 2];
    end else begin
      code   = dsq_pkg::CODE_NONE;
      any_ev = 1'b0;
    end
  end

  // Next value of all block state
  always_comb begin
    d        = q;
    d.ext_s1 = ext_event_in;
    d.ext_s2 = q.ext_s1;
    d.ext_q  = q.ext_s2;
    d.rdata  = 8'h00;

    // Configuration writes only while disarmed; flag and status ignore writes
    if (reg_wr && !q.arm) begin
      unique case (reg_addr)
        dsq_pkg::OFF_SCR1: d.scr1 = reg_wdata;
        dsq_pkg::OFF_SCR2: d.scr2 = reg_wdata;
        dsq_pkg::OFF_SCR3: d.scr3 = reg_wdata;
        dsq_pkg::OFF_CTRL: d.external_event_enable = reg_wdata[dsq_pkg::EXTERNAL_EVENT_ENABLE_LSB +: 2];
        default:           d.external_event_enable = q.external_event_enable;
      endcase
    end

    // Flags accumulate independently while armed
    if (q.arm) begin
      d.efr[3:0]               = q.efr[3:0] | {ch3_ev & (q.external_event_enable != dsq_pkg::EXTERNAL_EVENT_ENABLE_EXT)
                                 | match_in[3] & (q.external_event_enable != dsq_pkg::EXTERNAL_EVENT_ENABLE_EXT),
                                 match_in[2:0]};
      d.efr[dsq_pkg::FLAG_EXT] = q.efr[dsq_pkg::FLAG_EXT] | ext_ev;
    end

    // Session control; hardware end outranks a simultaneous write
    // A force request in the same write outranks a software disarm
    if (q.st == dsq_pkg::ST_FINAL) begin
      d.st  = dsq_pkg::ST_IDLE;
      d.state_status_field = dsq_pkg::SSF_IDLE;
      d.arm = 1'b0;
    end else if (arming) begin
      d.arm = 1'b1;
      d.efr = dsq_pkg::RST_EFR;
      d.st  = dsq_pkg::ST_S1;
      d.state_status_field = dsq_pkg::SSF_S1;
      if (force_req) begin
        d.st                       = dsq_pkg::ST_FINAL;
        d.state_status_field                      = dsq_pkg::SSF_FINAL;
        d.efr[dsq_pkg::FLAG_FORCE] = 1'b1;
      end
    end else if (wr_ctrl && q.arm && !reg_wdata[dsq_pkg::ARM_BIT] && !force_req) begin
      d.arm = 1'b0;
      d.st  = dsq_pkg::ST_IDLE;
    end else if (q.arm) begin
      if (force_req) begin
        d.st                       = dsq_pkg::ST_FINAL;
        d.state_status_field                      = dsq_pkg::SSF_FINAL;
        d.efr[dsq_pkg::FLAG_FORCE] = 1'b1;
      end else if (any_ev) begin
        d.st  = pick_state(q.st, code);
        d.state_status_field = ssf_of(d.st);
      end
    end

    // Read path; reads only sample, never modify
    if (reg_rd) begin
      unique case (reg_addr)
        dsq_pkg::OFF_CTRL:   d.rdata = {q.arm, 5'h00, q.external_event_enable};
        dsq_pkg::OFF_SCR1:   d.rdata = q.scr1;
        dsq_pkg::OFF_SCR2:   d.rdata = q.scr2;
        dsq_pkg::OFF_SCR3:   d.rdata = q.scr3;
        dsq_pkg::OFF_EFR:    d.rdata = q.efr;
        dsq_pkg::OFF_STATUS: d.rdata = {5'h00, q.state_status_field};
        default:             d.rdata = 8'h00;
      endcase
    end
  end

  // All state registered here
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      q.arm    <= 1'b0;
      q.external_event_enable   <= dsq_pkg::RST_EXTERNAL_EVENT_ENABLE;
      q.scr1   <= dsq_pkg::RST_SCR;
      q.scr2   <= dsq_pkg::RST_SCR;
      q.scr3   <= dsq_pkg::RST_SCR;
      q.efr    <= dsq_pkg::RST_EFR;
      q.state_status_field    <= dsq_pkg::SSF_IDLE;
      q.st     <= dsq_pkg::ST_IDLE;
      q.ext_s1 <= 1'b0;
      q.ext_s2 <= 1'b0;
      q.ext_q  <= 1'b0;
      q.rdata  <= 8'h00;
    end else begin
      q <= d;
    end
  end

  // Outputs straight from flops
  assign reg_rdata  = q.rdata;
  assign armed      = q.arm;
  assign state_code = q.state_status_field;

  // Checks next to the logic
  a_arm_entry:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (arming && !force_req && q.st != dsq_pkg::ST_FINAL)
    |=> (q.state_status_field == dsq_pkg::SSF_S1 && q.st == dsq_pkg::ST_S1 && q.efr == 8'h00))
    else $error("arming did not enter first state");

  a_scr2_lock:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q.arm && reg_wr && reg_addr == dsq_pkg::OFF_SCR2) |=> $stable(q.scr2))
    else $error("state 2 control written while armed");

  a_flags_sticky:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    !arming |=> ((q.efr & $past(q.efr)) == $past(q.efr)))
    else $error("event flag cleared without arming");

  a_match_flag:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q.arm && match_in[0]) |=> q.efr[0])
    else $error("match 0 flag not set while armed");

  a_ch3_prio:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q.arm && !wr_ctrl && q.st == dsq_pkg::ST_S2 && match_in[3] && match_in[0]
     && q.external_event_enable != dsq_pkg::EXTERNAL_EVENT_ENABLE_EXT && q.scr2[7:6] == 2'h3)
    |=> (q.st == dsq_pkg::ST_FINAL ##1 q.st == dsq_pkg::ST_IDLE && !q.arm))
    else $error("channel 3 priority or final exit wrong");

  a_s3_ch0:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q.arm && !wr_ctrl && q.st == dsq_pkg::ST_S3 && match_in[0] && !match_in[1]
     && !ch3_ev && q.scr3[1:0] == 2'h2)
    |=> (q.st == dsq_pkg::ST_S2 && q.state_status_field == dsq_pkg::SSF_S2))
    else $error("state 3 code 10 did not reach state 2");

  a_final_end:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q.st == dsq_pkg::ST_FINAL) |=> (q.state_status_field == dsq_pkg::SSF_IDLE && !q.arm))
    else $error("final state did not end session");

  a_sw_disarm:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q.arm && q.st != dsq_pkg::ST_FINAL && wr_ctrl && !reg_wdata[dsq_pkg::ARM_BIT]
     && !reg_wdata[dsq_pkg::FORCE_BIT])
    |=> (!q.arm && q.state_status_field == $past(q.state_status_field)))
    else $error("software disarm changed status");

  a_force_flag:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (force_req && q.st != dsq_pkg::ST_FINAL)
    |=> (q.efr[6] && q.state_status_field == dsq_pkg::SSF_FINAL))
    else $error("force request not recorded");

  a_read_clean:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && !q.arm && !arming) |=> ($stable(q.efr) && $stable(q.state_status_field)))
    else $error("read changed flags or status");

  // Register access, flag and status checks
  a_scr3_lock:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q.arm && reg_wr && reg_addr == dsq_pkg::OFF_SCR3) |=> $stable(q.scr3))
    else $error("state 3 control written while armed");

  a_ro_write:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_wr && !q.arm && (reg_addr == dsq_pkg::OFF_EFR || reg_addr == dsq_pkg::OFF_STATUS))
    |=> ($stable(q.efr) && $stable(q.state_status_field)))
    else $error("write reached a read-only register");

  a_idle_flags:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (!q.arm && !arming) |=> $stable(q.efr))
    else $error("event flag changed while disarmed");

  a_ext_flag:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q.arm && ext_ev) |=> q.efr[dsq_pkg::FLAG_EXT])
    else $error("external event flag not set while armed");

  a_ext_final:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q.arm && !wr_ctrl && q.st == dsq_pkg::ST_S2 && q.external_event_enable == dsq_pkg::EXTERNAL_EVENT_ENABLE_EXT && ext_ev
     && q.scr2[7:6] == 2'h3)
    |=> (q.st == dsq_pkg::ST_FINAL && q.state_status_field == dsq_pkg::SSF_FINAL))
    else $error("external event did not act as channel 3");

  a_status_track:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    q.arm |-> ((q.st == dsq_pkg::ST_S1 && q.state_status_field == dsq_pkg::SSF_S1)
           || (q.st == dsq_pkg::ST_S2 && q.state_status_field == dsq_pkg::SSF_S2)
           || (q.st == dsq_pkg::ST_S3 && q.state_status_field == dsq_pkg::SSF_S3)
           || (q.st == dsq_pkg::ST_FINAL && q.state_status_field == dsq_pkg::SSF_FINAL)))
    else $error("status field does not match sequencer state");

  a_status_legal:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q.state_status_field <= dsq_pkg::SSF_FINAL))
    else $error("reserved status code shown");

  a_force_read:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_rd && reg_addr == dsq_pkg::OFF_CTRL) |=> !reg_rdata[dsq_pkg::FORCE_BIT])
    else $error("force request bit read back as one");

  a_s2_ch1:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (q.arm && !wr_ctrl && q.st == dsq_pkg::ST_S2 && match_in[1] && !ch3_ev
     && q.scr2[3:2] == 2'h1)
    |=> (q.st == dsq_pkg::ST_S1 && q.state_status_field == dsq_pkg::SSF_S1))
    else $error("state 2 code 01 did not reach state 1");

  a_force_wins:
  assert property (@(posedge clk_sys) disable iff (!rst_n)
    (force_req && q.arm && q.st != dsq_pkg::ST_FINAL)
    |=> (q.arm && q.st == dsq_pkg::ST_FINAL))
    else $error("force request while armed did not reach final");

endmodule

// File: test/dsq_cmp_model.sv
// Comparator-side model: match channels and the external event pin.
// Assumes the bench commands it from clk_sys edges; no clock of its own.
module dsq_cmp_model (
  // Commands from the bench
  input  wire logic       cmp_en,
  input  wire logic [3:0] req_match,
  input  wire logic       req_ext,
  // Toward the sequencer
  output logic      [3:0] match_in,
  output logic            ext_event_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // A comparator left disabled never reports a match
  assign match_in = cmp_en ? req_match : 4'h0;
  // Pin level follows the event source directly
  assign ext_event_in = req_ext;
endmodule

// File: test/tb_top.sv
// Self-checking bench for the sequencer status block, integer model inside.
// Assumes dsq_top and dsq_pkg compiled first; one 25 MHz clock.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       clk_sys = 1'b0;
  logic       rst_n = 1'b0;
  logic [8:0] reg_addr = 9'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [3:0] match_in;
  logic       ext_event_in;
  logic       armed;
  logic [2:0] state_code;
  logic       cmp_en = 1'b1;
  logic [3:0] req_match = 4'h0;
  logic       req_ext = 1'b0;
  int         error_cnt = 0;
  int         tests_run = 0;
  int         seed = 21;
  int         e;
  int         k;
  int         m;
  int         s;
  int         scr;

  dsq_top dut_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .match_in(match_in), .ext_event_in(ext_event_in), .armed(armed),
    .state_code(state_code));
  dsq_cmp_model cmp_u (.cmp_en(cmp_en), .req_match(req_match), .req_ext(req_ext),
    .match_in(match_in), .ext_event_in(ext_event_in));

  // Free-running system clock
  always #20 clk_sys = ~clk_sys;

  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // One-cycle write; effect is visible just after the returning edge
  task automatic wr(logic [8:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    #1;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(logic [8:0] a, logic [7:0] exp);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    chk("rdata", reg_rdata, exp);
  endtask
  // Match held one cycle; the new state shows after the sampling edge
  task automatic pulse(logic [3:0] mv);
    @(posedge clk_sys);
    req_match <= mv;
    @(posedge clk_sys);
    req_match <= 4'h0;
    #1;
  endtask
  // Model: highest matching of channels 3, 1, 0 selects the code
  function automatic int nxt(int st, int sc, int mv);
    int c;
    c = mv[3] ? (sc >> 6) & 3 : mv[1] ? (sc >> 2) & 3 : mv[0] ? sc & 3 : 0;
    if (c == 0) return st;
    if (c == 1) return 1;
    if (c == 2) return (st == 2) ? 3 : 2;
    return 4;
  endfunction
  // Program, arm, walk into state st, then apply one match pattern
  task automatic run_case(int st, int sc, int mv);
    int ex;
    logic [8:0] a;
    a = (st == 2) ? dsq_pkg::OFF_SCR2 : dsq_pkg::OFF_SCR3;
    ex = nxt(st, sc, mv);
    wr(dsq_pkg::OFF_CTRL, 8'h00);
    wr(dsq_pkg::OFF_SCR1, (st == 2) ? 8'h01 : 8'h02);
    wr(a, sc[7:0]);
    rd(a, sc[7:0]);
    wr(dsq_pkg::OFF_CTRL, 8'h80);
    chk("state", {5'h00, state_code}, 8'h01);
    rd(dsq_pkg::OFF_EFR, 8'h00);
    pulse(4'h1);
    chk("state", {5'h00, state_code}, st[7:0]);
    pulse(mv[3:0]);
    chk("state", {5'h00, state_code}, ex[7:0]);
    if (ex == 4) begin
      @(posedge clk_sys);
      #1;
      chk("state", {5'h00, state_code}, 8'h00);
      chk("armed", {7'h00, armed}, 8'h00);
      ex = 0;
    end else begin
      wr(dsq_pkg::OFF_CTRL, 8'h00);
      chk("armed", {7'h00, armed}, 8'h00);
    end
    rd(dsq_pkg::OFF_EFR, 8'h01 | mv[7:0]);
    rd(dsq_pkg::OFF_EFR, 8'h01 | mv[7:0]);
    rd(dsq_pkg::OFF_STATUS, ex[7:0]);
  endtask

  // Watchdog sized well beyond the expected run
  initial begin
    #(40 * 30000);
    error_cnt++;
    tally_and_finish();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    rd(dsq_pkg::OFF_SCR2, 8'h00);
    rd(dsq_pkg::OFF_SCR3, 8'h00);
    rd(dsq_pkg::OFF_EFR, 8'h00);
    rd(dsq_pkg::OFF_STATUS, 8'h00);
    // Every code of every channel in both states, then random mixes
    for (s = 2; s <= 3; s++) begin
      for (k = 0; k < 12; k++) begin
        m = (k < 4) ? 1 : (k < 8) ? 2 : 8;
        scr = (k % 4) << ((k < 4) ? 0 : (k < 8) ? 2 : 6);
        run_case(s, scr, m);
      end
    end
    for (k = 0; k < 10; k++) begin
      s = 2 + ($random(seed) & 1);
      scr = $random(seed) & 255;
      m = $random(seed) & 15;
      if (m == 0) m = 8;
      run_case(s, scr, m);
    end
    // Fixed mixes: 3 over 0, 1 over 0, a 00 code on top still wins
    run_case(2, 8'hC1, 9);
    run_case(3, 8'h09, 3);
    run_case(2, 8'h04, 10);
    // External event stands in for channel 3
    wr(dsq_pkg::OFF_CTRL, 8'h02);
    wr(dsq_pkg::OFF_SCR1, 8'h01);
    wr(dsq_pkg::OFF_SCR2, 8'hC0);
    wr(dsq_pkg::OFF_CTRL, 8'h82);
    rd(dsq_pkg::OFF_CTRL, 8'h82);
    pulse(4'h1);
    pulse(4'h8);
    chk("state", {5'h00, state_code}, 8'h02);
    @(posedge clk_sys);
    req_ext <= 1'b1;
    e = 0;
    while (state_code !== 3'h4 && e < 10) begin
      @(posedge clk_sys);
      #1;
      e++;
    end
    chk("state", {5'h00, state_code}, 8'h04);
    @(posedge clk_sys);
    req_ext <= 1'b0;
    rd(dsq_pkg::OFF_EFR, 8'h11);
    // Force on the arming write, then while armed
    wr(dsq_pkg::OFF_CTRL, 8'h00);
    wr(dsq_pkg::OFF_CTRL, 8'hC0);
    chk("state", {5'h00, state_code}, 8'h04);
    rd(dsq_pkg::OFF_EFR, 8'h40);
    wr(dsq_pkg::OFF_CTRL, 8'h80);
    wr(dsq_pkg::OFF_SCR2, 8'h55);
    rd(dsq_pkg::OFF_SCR2, 8'hC0);
    wr(dsq_pkg::OFF_CTRL, 8'hC0);
    chk("state", {5'h00, state_code}, 8'h04);
    // Disarmed matches and writes to read-only places leave no mark
    pulse(4'hF);
    wr(dsq_pkg::OFF_EFR, 8'hFF);
    wr(dsq_pkg::OFF_STATUS, 8'hFF);
    rd(dsq_pkg::OFF_EFR, 8'h40);
    rd(dsq_pkg::OFF_STATUS, 8'h00);
    rd(9'h1FF, 8'h00);
    // Disabled comparators leave no mark; enable field 01 keeps channel 3
    @(posedge clk_sys);
    cmp_en <= 1'b0;
    wr(dsq_pkg::OFF_CTRL, 8'h81);
    pulse(4'hF);
    chk("state", {5'h00, state_code}, 8'h01);
    rd(dsq_pkg::OFF_EFR, 8'h00);
    @(posedge clk_sys);
    cmp_en <= 1'b1;
    pulse(4'h1);
    pulse(4'h8);
    chk("state", {5'h00, state_code}, 8'h04);
    rd(dsq_pkg::OFF_EFR, 8'h09);
    // Force without the arm bit while armed still reaches final
    wr(dsq_pkg::OFF_CTRL, 8'h80);
    pulse(4'h1);
    wr(dsq_pkg::OFF_CTRL, 8'h40);
    chk("state", {5'h00, state_code}, 8'h04);
    rd(dsq_pkg::OFF_EFR, 8'h41);
    chk("armed", {7'h00, armed}, 8'h00);
    tally_and_finish();
  end
endmodule
